// ---- core/asg_pkg.sv ----
package asg_pkg;
  localparam int SAMPLE_BITS_DEF = 12;
  localparam int CNT_W = 6;
  localparam int ADDR_W = 4;
  localparam int ROW_W = 4;
  localparam int PIN_W = 18;
  localparam logic [CNT_W-1:0] CNT_RST = 6'h3f;
  localparam logic [ROW_W-1:0] ROWS_IDLE = 4'hf;

  typedef logic [ADDR_W-1:0] asg_addr_t;
  typedef logic [ROW_W-1:0] asg_rows_t;
  typedef logic [PIN_W-1:0] asg_vec_t;

  // order of address bits: 15, 14, 5, 4
  typedef struct packed {
    logic bclk;
    logic conv_sel;
    logic wsync;
    logic dout_v;
    logic dout_a;
    asg_rows_t rows;
    logic sys_reset;
    asg_addr_t addr;
    logic rd_n;
    logic wr_n;
    logic ds_sel;
    logic ps_sel;
  } asg_pins_s;

  typedef struct packed {
    logic conv_clk_n;
    logic conv_cs_n;
    logic rx;
    logic key_irq_n;
    logic gain_cs_n;
    logic wave_cs_n;
  } asg_out_s;

  typedef struct packed {
    asg_vec_t s1;
    asg_vec_t s2;
    asg_vec_t s3;
    asg_pins_s filt;
    logic bclk_prev;
    logic [CNT_W-1:0] bit_cnt;
    asg_out_s out;
  } asg_state_s;

  localparam asg_pins_s PINS_RST = '{bclk: 1'b0, conv_sel: 1'b0, wsync: 1'b0, dout_v: 1'b0,
    dout_a: 1'b0, rows: 4'hf, sys_reset: 1'b1, addr: 4'h0, rd_n: 1'b1, wr_n: 1'b1,
    ds_sel: 1'b1, ps_sel: 1'b1};
  localparam asg_out_s OUT_RST = '{conv_clk_n: 1'b1, conv_cs_n: 1'b1, rx: 1'b0,
    key_irq_n: 1'b1, gain_cs_n: 1'b1, wave_cs_n: 1'b1};
endpackage : asg_pkg

// ---- core/asg_glue.sv ----
module asg_glue #(
  parameter int SAMPLE_BITS = asg_pkg::SAMPLE_BITS_DEF,
  parameter asg_pkg::asg_addr_t GAIN_ADDR = 4'h8,
  parameter logic GAIN_DS = 1'b0,
  parameter logic GAIN_PS = 1'b1,
  parameter asg_pkg::asg_addr_t WAVE_ADDR = 4'h4,
  parameter logic WAVE_DS = 1'b0,
  parameter logic WAVE_PS = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // serial port from the processor
  input wire logic bit_clk,
  input wire logic converter_select,
  input wire logic word_sync,
  output logic serial_rx_line,
  // converters
  input wire logic dout_volts,
  input wire logic dout_amps,
  output logic conv_clk_n,
  output logic conv_cs_n,
  // keypad
  input wire asg_pkg::asg_rows_t key_rows,
  input wire logic sys_reset_line,
  output logic key_irq_n,
  // memory bus decode
  input wire asg_pkg::asg_addr_t bus_addr,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic data_space_select,
  input wire logic program_space_select,
  output logic gain_cs_n,
  output logic wave_cs_n
);
  import asg_pkg::*;

  // the gate counter saturates at CNT_RST, so it must stay above the sample length
  if (SAMPLE_BITS < 1 || SAMPLE_BITS >= 63) begin : g_bad_bits
    $error("SAMPLE_BITS out of range");
  end

  localparam logic [CNT_W-1:0] SB = CNT_W'(SAMPLE_BITS);

  function automatic logic addr_hit(input asg_pins_s p, input asg_addr_t a,
                                    input logic ds, input logic ps);
    addr_hit = (p.addr == a) && (p.ds_sel == ds) && (p.ps_sel == ps);
  endfunction : addr_hit

  asg_pins_s raw;
  asg_pins_s f;
  asg_state_s st_q;
  asg_state_s st_d;
  logic rise;
  logic gain_hit;
  logic wave_hit;

  always_comb begin
    raw.bclk = bit_clk;
    raw.conv_sel = converter_select;
    raw.wsync = word_sync;
    raw.dout_v = dout_volts;
    raw.dout_a = dout_amps;
    raw.rows = key_rows;
    raw.sys_reset = sys_reset_line;
    raw.addr = bus_addr;
    raw.rd_n = rd_n;
    raw.wr_n = wr_n;
    raw.ds_sel = data_space_select;
    raw.ps_sel = program_space_select;
  end

  assign f = st_q.filt;
  assign rise = f.bclk & ~st_q.bclk_prev;
  assign gain_hit = addr_hit(f, GAIN_ADDR, GAIN_DS, GAIN_PS);
  assign wave_hit = addr_hit(f, WAVE_ADDR, WAVE_DS, WAVE_PS);

  always_comb begin
    asg_vec_t fv;
    fv = asg_vec_t'(st_q.filt);
    st_d = st_q;
    // every pin is asynchronous to core_clk; a level counts once stages two and three agree
    st_d.s1 = asg_vec_t'(raw);
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < PIN_W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        fv[i] = st_q.s3[i];
      end
    end
    st_d.filt = asg_pins_s'(fv);
    st_d.bclk_prev = f.bclk;

    // bit count restarts at each word sync
    if (rise) begin
      if (f.wsync) begin
        st_d.bit_cnt = '0;
      end else if (st_q.bit_cnt != CNT_RST) begin
        st_d.bit_cnt = st_q.bit_cnt + CNT_W'(1);
      end
    end

    st_d.out.conv_clk_n = ~f.bclk;
    // shared select from sync and select only
    st_d.out.conv_cs_n = ~(f.wsync & ~f.conv_sel);
    // mux volts/amps, only the top bits of each word
    if (st_d.bit_cnt < SB) begin
      st_d.out.rx = f.conv_sel ? f.dout_a : f.dout_v;
    end else begin
      st_d.out.rx = 1'b0;
    end
    // rows are active low, gated by the reset line
    st_d.out.key_irq_n = ~(~f.sys_reset & (f.rows != ROWS_IDLE));
    // gain strobe ends as the write ends, so the data is valid at its rise
    st_d.out.gain_cs_n = ~(gain_hit & ~f.wr_n);
    // same decode for read and write
    st_d.out.wave_cs_n = ~(wave_hit & (~f.rd_n | ~f.wr_n));
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      // selects and strobes high in reset
      st_q.s1 <= asg_vec_t'(PINS_RST);
      st_q.s2 <= asg_vec_t'(PINS_RST);
      st_q.s3 <= asg_vec_t'(PINS_RST);
      st_q.filt <= PINS_RST;
      st_q.bclk_prev <= 1'b0;
      st_q.bit_cnt <= CNT_RST;
      st_q.out <= OUT_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign conv_clk_n = st_q.out.conv_clk_n;
  assign conv_cs_n = st_q.out.conv_cs_n;
  assign serial_rx_line = st_q.out.rx;
  assign key_irq_n = st_q.out.key_irq_n;
  assign gain_cs_n = st_q.out.gain_cs_n;
  assign wave_cs_n = st_q.out.wave_cs_n;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  sequence word_start_s;
    rise && f.wsync;
  endsequence

  sequence volts_bit_s;
    (st_d.bit_cnt < SB) && !f.conv_sel;
  endsequence

  sequence amps_bit_s;
    (st_d.bit_cnt < SB) && f.conv_sel;
  endsequence

  sequence key_press_s;
    !f.sys_reset && (f.rows != ROWS_IDLE);
  endsequence

  sequence gain_write_s;
    gain_hit && !f.wr_n;
  endsequence

  clk_invert_a: assert property (1'b1 |=> conv_clk_n != $past(f.bclk))
    else $error("converter clock is not the inverse of bit clock");

  conv_select_a: assert property ((f.wsync && !f.conv_sel) |=> !conv_cs_n)
    else $error("converter select missing on word sync");

  select_cause_a: assert property ($changed(conv_cs_n) |->
    ($past(f.wsync, 2) != $past(f.wsync) || $past(f.conv_sel, 2) != $past(f.conv_sel)))
    else $error("converter select moved without a cause");

  word_count_a: assert property (word_start_s ##1 (!rise)[*2] |-> st_q.bit_cnt == 6'h0)
    else $error("bit count not restarted by word sync");

  volts_pass_a: assert property (volts_bit_s |=> serial_rx_line == $past(f.dout_v))
    else $error("volts data not passed");

  amps_pass_a: assert property (amps_bit_s |=> serial_rx_line == $past(f.dout_a))
    else $error("amps data not passed");

  word_limit_a: assert property ((st_d.bit_cnt >= SB) |=> !serial_rx_line)
    else $error("bits beyond the sample length leaked");

  key_irq_a: assert property (key_press_s |=> !key_irq_n)
    else $error("key interrupt not raised");

  key_idle_a: assert property ((f.rows == ROWS_IDLE) |=> key_irq_n)
    else $error("key interrupt without a pressed row");

  gain_strobe_a: assert property (gain_write_s ##1 f.wr_n |=> gain_cs_n)
    else $error("gain strobe did not rise after the write");

  gain_decode_a: assert property (gain_write_s |=> !gain_cs_n)
    else $error("gain strobe missing");

  wave_decode_a: assert property ((wave_hit && (!f.rd_n || !f.wr_n)) |=> !wave_cs_n)
    else $error("waveform select missing");

  gain_read_a: assert property (f.wr_n |=> gain_cs_n)
    else $error("gain strobe without a write");

  wave_idle_a: assert property ((f.rd_n && f.wr_n) |=> wave_cs_n)
    else $error("waveform select without a strobe");

  gain_miss_a: assert property (!gain_hit |=> gain_cs_n)
    else $error("gain strobe outside its address");

  wave_miss_a: assert property (!wave_hit |=> wave_cs_n)
    else $error("waveform select outside its address");

  conv_idle_a: assert property (!f.wsync |=> conv_cs_n)
    else $error("converter select without word sync");

  amps_nocs_a: assert property (f.conv_sel |=> conv_cs_n)
    else $error("converter select on the amps word");

  key_gate_a: assert property (f.sys_reset |=> key_irq_n)
    else $error("key interrupt while reset line high");

  count_hold_a: assert property (!rise |=> $stable(st_q.bit_cnt))
    else $error("bit count moved without a bit clock rise");

  reset_hold_a: assert property (@(posedge core_clk) disable iff (1'b0)
    reset |=> (conv_cs_n && gain_cs_n && wave_cs_n && key_irq_n))
    else $error("select asserted during reset");

endmodule : asg_glue

// ---- test/asg_proc_model.sv ----
module asg_proc_model (
  // clock
  input wire logic core_clk,
  // serial port and converter data
  output logic bit_clk,
  output logic converter_select,
  output logic word_sync,
  output logic dout_volts,
  output logic dout_amps
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    bit_clk = 1'b0;
    converter_select = 1'b0;
    word_sync = 1'b0;
    dout_volts = 1'b0;
    dout_amps = 1'b1;
  end

  // one 16-bit word, 32 ns bit period; data changes on the low phase
  task automatic send_word(input logic sel, input logic [15:0] vw, input logic [15:0] aw);
    for (int i = 0; i < 16; i++) begin
      @(negedge core_clk);
      bit_clk <= 1'b0;
      converter_select <= sel;
      // sync one bit wide at word start
      word_sync <= (i == 0);
      // each converter on its own line
      dout_volts <= vw[15-i];
      dout_amps <= aw[15-i];
      repeat (4) @(negedge core_clk);
      bit_clk <= 1'b1;
      repeat (3) @(negedge core_clk);
    end
    @(negedge core_clk);
    // clock stands still between words; released data must not look stale
    bit_clk <= 1'b0;
    word_sync <= 1'b0;
    dout_volts <= ~dout_volts;
    dout_amps <= ~dout_amps;
  endtask : send_word
endmodule : asg_proc_model

// ---- test/tb_adc_serial_mux_glue.sv ----
module tb_adc_serial_mux_glue;
  timeunit 1ns;
  timeprecision 1ps;
  import asg_pkg::*;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic bit_clk, converter_select, word_sync, dout_volts, dout_amps;
  logic serial_rx_line, conv_clk_n, conv_cs_n, key_irq_n, gain_cs_n, wave_cs_n;
  asg_rows_t key_rows = ROWS_IDLE;
  asg_addr_t bus_addr = 4'h0;
  logic sys_reset_line = 1'b1;
  logic rd_n = 1'b1;
  logic wr_n = 1'b1;
  logic data_space_select = 1'b1;
  logic program_space_select = 1'b1;
  int n_errors = 0;
  int compares = 0;

  always #2 core_clk = ~core_clk;

  asg_glue asg_glue_inst (.core_clk, .reset, .bit_clk, .converter_select, .word_sync, .serial_rx_line,
    .dout_volts, .dout_amps, .conv_clk_n, .conv_cs_n, .key_rows, .sys_reset_line, .key_irq_n,
    .bus_addr, .rd_n, .wr_n, .data_space_select, .program_space_select, .gain_cs_n, .wave_cs_n);
  asg_proc_model asg_proc_model_inst (.core_clk, .bit_clk, .converter_select, .word_sync,
    .dout_volts, .dout_amps);

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic check(input logic seen, input logic exp, input string what);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: %s saw %b want %b", $time, what, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test

  // each check looks mid-bit, after the fixed five-edge latency has passed
  task automatic test_word(input logic sel, input logic [15:0] vw, input logic [15:0] aw);
    logic [15:0] w;
    w = sel ? aw : vw;
    fork
      asg_proc_model_inst.send_word(sel, vw, aw);
      begin
        cyc(11);
        for (int i = 0; i < 16; i++) begin
          check(serial_rx_line, (i < SAMPLE_BITS_DEF) ? w[15-i] : 1'b0, "rx bit");
          check(conv_clk_n, 1'b0, "conv clock high");
          if (i < 2) check(conv_cs_n, (i == 0) ? sel : 1'b1, "conv select");
          cyc(4);
          check(conv_clk_n, 1'b1, "conv clock low");
          cyc(4);
        end
      end
    join
    $display("test_word sel %b done", sel);
  endtask : test_word

  task automatic test_keys;
    for (int r = 0; r < 5; r++) begin
      sys_reset_line = (r == 4);
      // columns held low, one row pulled low at a time
      key_rows = ROWS_IDLE & ~(4'h1 << r[1:0]);
      cyc(6);
      check(key_irq_n, (r == 4), "irq row low");
      key_rows = ROWS_IDLE;
      cyc(6);
      check(key_irq_n, 1'b1, "irq rows idle");
    end
    $display("test_keys done");
  endtask : test_keys

  // entry: addr, rd_n, wr_n, data space, program space, gain expected, wave expected
  task automatic test_decode;
    logic [9:0] t [8] = '{10'h225, 10'h217, 10'h116, 10'h126, 10'h11f, 10'h223, 10'h327, 10'h137};
    // range codes ride the data bus; only the strobe is seen here
    foreach (t[k]) begin
      {bus_addr, rd_n, wr_n, data_space_select, program_space_select} = t[k][9:2];
      cyc(6);
      check(gain_cs_n, t[k][1], "gain strobe");
      check(wave_cs_n, t[k][0], "wave select");
      {rd_n, wr_n} = 2'h3;
      cyc(6);
      check(gain_cs_n & wave_cs_n, 1'b1, "strobes released");
    end
    $display("test_decode done");
  endtask : test_decode

  // a core reset in mid-access must force every select high at once
  task automatic test_reset;
    {bus_addr, rd_n, wr_n, data_space_select, program_space_select} = 8'h45;
    sys_reset_line = 1'b0;
    key_rows = 4'he;
    cyc(6);
    check(wave_cs_n, 1'b0, "wave before reset");
    reset = 1'b1;
    cyc(2);
    check(wave_cs_n & gain_cs_n & conv_cs_n & key_irq_n, 1'b1, "selects in reset");
    check(serial_rx_line, 1'b0, "rx in reset");
    reset = 1'b0;
    cyc(6);
    check(key_irq_n, 1'b0, "irq after reset");
    {rd_n, key_rows} = {1'b1, ROWS_IDLE};
    $display("test_reset done");
  endtask : test_reset

  initial begin
    cyc(3);
    reset = 1'b0;
    cyc(2);
    // two words stand for a burst; the quiet tests after it are the processing gap
    test_word(1'b0, 16'ha5cf, 16'h5a30);
    test_word(1'b1, 16'h5a30, 16'h3c9f);
    test_keys();
    test_decode();
    test_reset();
    end_of_test();
  end

  initial begin
    cyc(20000);
    n_errors++;
    end_of_test();
  end
endmodule : tb_adc_serial_mux_glue
